//--- shared/gpio_port_pkg.sv
`default_nettype none
package gpio_port_pkg;

    localparam int NUM_PORTS    = 8;
    localparam int PORT_MAX_W   = 8;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;
    localparam int PORT_FIELD_W = 3;
    localparam int SEL_FIELD_W  = 2;
    localparam int IRQ_W        = 3;

    // address layout: bit 7 set is unmapped, bits 6:4 port, bits 3:2 register
    localparam int SEL_LSB        = 2;
    localparam int PORT_LSB       = 4;
    localparam int MAP_BIT        = 7;
    localparam int STRB_DATA_LANE = 0;

    localparam logic [SEL_FIELD_W-1:0] SEL_DATA = 2'h0;
    localparam logic [SEL_FIELD_W-1:0] SEL_DIR  = 2'h1;
    localparam logic [SEL_FIELD_W-1:0] SEL_PULL = 2'h2;
    localparam logic [SEL_FIELD_W-1:0] SEL_ALT  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int PORT_WIDTH [NUM_PORTS] = '{7, 8, 8, 4, 4, 4, 4, 8};

    // one bit per port index
    localparam logic [NUM_PORTS-1:0] OUT_PORTS    = 8'hfb;
    localparam logic [NUM_PORTS-1:0] OD_PORTS     = 8'h40;
    localparam logic [NUM_PORTS-1:0] SWPU_PORTS   = 8'hbb;
    localparam logic [NUM_PORTS-1:0] ALT_PORTS    = 8'h83;
    localparam logic [NUM_PORTS-1:0] ANALOG_PORTS = 8'h04;

    localparam int PORT_P0  = 0;
    localparam int PORT_P1  = 1;
    localparam int PORT_ADC = 2;
    localparam int PORT_IRQ = 3;
    localparam int PORT_P4  = 4;
    localparam int PORT_P5  = 5;
    localparam int PORT_OD  = 6;
    localparam int PORT_KEY = 7;

    typedef logic [PORT_MAX_W-1:0] port_word_t;

    localparam port_word_t LATCH_RESET = 8'h00;
    localparam port_word_t DIR_RESET   = 8'hff;
    localparam port_word_t PULL_RESET  = 8'h00;
    localparam port_word_t ALT_RESET   = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK  = 2'b01,
        ST_RESP = 2'b10
    } bus_state_t;

    function automatic port_word_t width_mask(input int w);
        return port_word_t'((1 << w) - 1);
    endfunction

endpackage
`default_nettype wire

//--- shared/port_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface port_bank_if;
    import gpio_port_pkg::*;
    port_word_t wrData;
    logic       wrLatch;
    logic       wrDir;
    logic       wrPull;
    logic       wrAlt;
    port_word_t latch;
    port_word_t dirIn;
    port_word_t pull;
    port_word_t alt;
    port_word_t level;
    modport ctrl (output wrData, wrLatch, wrDir, wrPull, wrAlt,
                  input  latch, dirIn, pull, alt, level);
    modport bank (input  wrData, wrLatch, wrDir, wrPull, wrAlt,
                  output latch, dirIn, pull, alt, level);
endinterface
`default_nettype wire

//--- rtl/port_bank.sv
`timescale 1ns/1ps
`default_nettype none
module port_bank #(
    parameter int                        WIDTH       = 8,
    parameter bit                        HAS_OUT     = 1'b1,
    parameter bit                        OPEN_DRAIN  = 1'b0,
    parameter bit                        SW_PULLUP   = 1'b1,
    parameter bit                        HAS_ALT     = 1'b0,
    parameter bit                        ANALOG      = 1'b0,
    parameter gpio_port_pkg::port_word_t MASK_PULLUP = 8'h00
) (
    input  wire logic                      clk_sys,  // system clock
    input  wire logic                      rst,      // async reset, high
    port_bank_if.bank                      bus,      // register strobes and readback
    input  wire gpio_port_pkg::port_word_t pinIn,    // pad level
    input  wire gpio_port_pkg::port_word_t altOut,   // peripheral drive data
    input  wire gpio_port_pkg::port_word_t altOe,    // peripheral drive enable
    output var  gpio_port_pkg::port_word_t pinOut,   // pad drive data
    output var  gpio_port_pkg::port_word_t pinOe,    // pad drive enable
    output var  gpio_port_pkg::port_word_t pullupOn  // pull-up switch
);
    import gpio_port_pkg::*;

    localparam port_word_t WMASK = width_mask(WIDTH);

    port_word_t outLatch_reg;
    port_word_t dirIn_reg;
    port_word_t pullEn_reg;
    port_word_t altSel_reg;
    port_word_t level_reg;
    port_word_t driveData;
    port_word_t driveEn;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outLatch_reg <= LATCH_RESET;
        end else if (bus.wrLatch && HAS_OUT) begin
            outLatch_reg <= bus.wrData & WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dirIn_reg <= DIR_RESET & WMASK;
        end else if (bus.wrDir && HAS_OUT) begin
            dirIn_reg <= bus.wrData & WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pullEn_reg <= PULL_RESET;
        end else if (bus.wrPull && SW_PULLUP) begin
            pullEn_reg <= bus.wrData & WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            altSel_reg <= ALT_RESET;
        end else if (bus.wrAlt && (HAS_ALT || ANALOG)) begin
            altSel_reg <= bus.wrData & WMASK;
        end
    end

    // analog-selected bits have their digital buffer off and read low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_reg <= '0;
        end else begin
            level_reg <= pinIn & WMASK & ~(ANALOG ? altSel_reg : '0);
        end
    end

    always_comb begin
        driveData = outLatch_reg;
        driveEn   = ~dirIn_reg;
        if (HAS_ALT) begin
            driveData = (altSel_reg & altOut) | (~altSel_reg & outLatch_reg);
            driveEn   = (altSel_reg & altOe) | (~altSel_reg & ~dirIn_reg);
        end
        driveEn = HAS_OUT ? (driveEn & WMASK) : '0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinOut   <= '0;
            pinOe    <= '0;
            pullupOn <= '0;
        end else begin
            pinOut   <= OPEN_DRAIN ? '0 : (driveData & WMASK);
            pinOe    <= OPEN_DRAIN ? (driveEn & ~driveData) : driveEn;
            if (OPEN_DRAIN) begin
                pullupOn <= MASK_PULLUP & WMASK;
            end else if (SW_PULLUP) begin
                pullupOn <= pullEn_reg & dirIn_reg & ~(altSel_reg & altOe);
            end else begin
                pullupOn <= '0;
            end
        end
    end

    assign bus.latch = outLatch_reg;
    assign bus.dirIn = dirIn_reg;
    assign bus.pull  = pullEn_reg;
    assign bus.alt   = altSel_reg;
    assign bus.level = level_reg;

endmodule
`default_nettype wire

//--- rtl/mcu_port_pin_block.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_port_pin_block #(
    parameter gpio_port_pkg::port_word_t MASK_PULLUP_OD = 8'h00
) (
    input  wire logic                                          clk_sys,         // 25 MHz
    input  wire logic                                          rst,             // async, high
    input  wire logic [gpio_port_pkg::ADDR_W-1:0]              s_axi_awaddr,    // write addr
    input  wire logic                                          s_axi_awvalid,   // addr valid
    output var  logic                                          s_axi_awready,   // addr ready
    input  wire logic [gpio_port_pkg::DATA_W-1:0]              s_axi_wdata,     // write data
    input  wire logic [gpio_port_pkg::DATA_W/8-1:0]            s_axi_wstrb,     // byte enables
    input  wire logic                                          s_axi_wvalid,    // data valid
    output var  logic                                          s_axi_wready,    // data ready
    output var  logic [1:0]                                    s_axi_bresp,     // write resp
    output var  logic                                          s_axi_bvalid,    // resp valid
    input  wire logic                                          s_axi_bready,    // resp ready
    input  wire logic [gpio_port_pkg::ADDR_W-1:0]              s_axi_araddr,    // read addr
    input  wire logic                                          s_axi_arvalid,   // addr valid
    output var  logic                                          s_axi_arready,   // addr ready
    output var  logic [gpio_port_pkg::DATA_W-1:0]              s_axi_rdata,     // read data
    output var  logic [1:0]                                    s_axi_rresp,     // read resp
    output var  logic                                          s_axi_rvalid,    // data valid
    input  wire logic                                          s_axi_rready,    // data ready
    input  wire gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] pinIn,    // pad in
    input  wire gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] altOut,   // periph
    input  wire gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] altOe,    // periph
    output var  gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] pinOut,   // pad out
    output var  gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] pinOe,    // pad oe
    output var  gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] pullupOn, // pull-up
    output var  gpio_port_pkg::port_word_t [gpio_port_pkg::NUM_PORTS-1:0] altIn,    // levels
    output var  logic [gpio_port_pkg::PORT_MAX_W-1:0]          key_return_inputs, // port 7
    output var  logic [gpio_port_pkg::IRQ_W-1:0]               ext_irq_inputs,  // port 3
    output var  logic [gpio_port_pkg::PORT_MAX_W-1:0]          analog_inputs    // adc select
);
    import gpio_port_pkg::*;

    bus_state_t                wrState_reg;
    bus_state_t                rdState_reg;
    logic                      wrFire;
    logic                      wrMapped;
    logic                      rdMapped;
    logic [PORT_FIELD_W-1:0]   wrPort;
    logic [PORT_FIELD_W-1:0]   rdPort;
    logic [SEL_FIELD_W-1:0]    wrSel;
    logic [SEL_FIELD_W-1:0]    rdSel;
    port_word_t                rdWord;
    port_word_t                rdLatch [NUM_PORTS];
    port_word_t                rdDir   [NUM_PORTS];
    port_word_t                rdPull  [NUM_PORTS];
    port_word_t                rdAlt   [NUM_PORTS];
    port_word_t                rdLevel [NUM_PORTS];

    assign wrPort   = s_axi_awaddr[PORT_LSB +: PORT_FIELD_W];
    assign wrSel    = s_axi_awaddr[SEL_LSB +: SEL_FIELD_W];
    assign wrMapped = ~s_axi_awaddr[MAP_BIT];
    assign rdPort   = s_axi_araddr[PORT_LSB +: PORT_FIELD_W];
    assign rdSel    = s_axi_araddr[SEL_LSB +: SEL_FIELD_W];
    assign rdMapped = ~s_axi_araddr[MAP_BIT];

    // address and data are held valid through ST_ACK, so decode them there
    assign wrFire = (wrState_reg == ST_ACK) && wrMapped && s_axi_wstrb[STRB_DATA_LANE];

    // write channel: waits for both address and data, so their order is free
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrState_reg   <= ST_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            case (wrState_reg)
                ST_IDLE: begin
                    if (s_axi_awvalid && s_axi_wvalid) begin
                        wrState_reg   <= ST_ACK;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                ST_ACK: begin
                    wrState_reg   <= ST_RESP;
                    s_axi_awready <= 1'b0;
                    s_axi_wready  <= 1'b0;
                    s_axi_bvalid  <= 1'b1;
                    s_axi_bresp   <= wrMapped ? RESP_OKAY : RESP_SLVERR;
                end
                ST_RESP: begin
                    if (s_axi_bready) begin
                        wrState_reg  <= ST_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wrState_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // data register reads the latch for outputs and the pad for inputs
    always_comb begin
        rdWord = '0;
        case (rdSel)
            SEL_DATA: begin
                rdWord = (rdLatch[rdPort] & ~rdDir[rdPort]) |
                         (rdLevel[rdPort] & rdDir[rdPort]);
            end
            SEL_DIR: begin
                rdWord = rdDir[rdPort];
            end
            SEL_PULL: begin
                rdWord = rdPull[rdPort];
            end
            default: begin
                rdWord = rdAlt[rdPort];
            end
        endcase
        if (!rdMapped) begin
            rdWord = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdState_reg   <= ST_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rdState_reg)
                ST_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState_reg   <= ST_ACK;
                        s_axi_arready <= 1'b1;
                    end
                end
                ST_ACK: begin
                    rdState_reg   <= ST_RESP;
                    s_axi_arready <= 1'b0;
                    s_axi_rvalid  <= 1'b1;
                    s_axi_rdata   <= {{(DATA_W-PORT_MAX_W){1'b0}}, rdWord};
                    s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
                end
                ST_RESP: begin
                    if (s_axi_rready) begin
                        rdState_reg  <= ST_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    rdState_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // one bank per port; the masks give each port its documented character
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        port_bank_if bif ();

        port_bank #(
            .WIDTH       (PORT_WIDTH[p]),
            .HAS_OUT     (OUT_PORTS[p]),
            .OPEN_DRAIN  (OD_PORTS[p]),
            .SW_PULLUP   (SWPU_PORTS[p]),
            .HAS_ALT     (ALT_PORTS[p]),
            .ANALOG      (ANALOG_PORTS[p]),
            .MASK_PULLUP ((p == PORT_OD) ? MASK_PULLUP_OD : '0)
        ) u_bank (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .bus      (bif),
            .pinIn    (pinIn[p]),
            .altOut   (altOut[p]),
            .altOe    (altOe[p]),
            .pinOut   (pinOut[p]),
            .pinOe    (pinOe[p]),
            .pullupOn (pullupOn[p])
        );

        assign bif.wrData  = s_axi_wdata[PORT_MAX_W-1:0];
        assign bif.wrLatch = wrFire && (wrPort == PORT_FIELD_W'(p)) && (wrSel == SEL_DATA);
        assign bif.wrDir   = wrFire && (wrPort == PORT_FIELD_W'(p)) && (wrSel == SEL_DIR);
        assign bif.wrPull  = wrFire && (wrPort == PORT_FIELD_W'(p)) && (wrSel == SEL_PULL);
        assign bif.wrAlt   = wrFire && (wrPort == PORT_FIELD_W'(p)) && (wrSel == SEL_ALT);
        assign rdLatch[p]  = bif.latch;
        assign rdDir[p]    = bif.dirIn;
        assign rdPull[p]   = bif.pull;
        assign rdAlt[p]    = bif.alt;
        assign rdLevel[p]  = bif.level;
        assign altIn[p]    = bif.level;

        // pull-up never on for a pin set to output the cycle before, except the fixed MASK_PULLUP_OD bits of the open-drain port
        property p_pullup_input;
            @(posedge clk_sys) disable iff (rst)
            !$past(rst) |->
                (pullupOn[p] & ~$past(rdDir[p]) & ~((p == PORT_OD) ? MASK_PULLUP_OD : '0)) == '0;
        endproperty
        a_pullup_input: assert property (p_pullup_input)
            else $error("pull-up enabled on a pin in output mode");
    end

    assign key_return_inputs = rdLevel[PORT_KEY];
    assign ext_irq_inputs    = rdLevel[PORT_IRQ][IRQ_W-1:0];
    assign analog_inputs     = rdAlt[PORT_ADC];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_dirWrite1;
        wrFire && (wrPort == PORT_FIELD_W'(PORT_P1)) && (wrSel == SEL_DIR) &&
        (rdAlt[PORT_P1] == '0);
    endsequence

    sequence s_p2Write;
        wrFire && (wrPort == PORT_FIELD_W'(PORT_ADC));
    endsequence

    sequence s_p2DataRead;
        (rdState_reg == ST_ACK) && rdMapped && (rdPort == PORT_FIELD_W'(PORT_ADC)) &&
        (rdSel == SEL_DATA);
    endsequence

    property p_reset_inputs;
        $fell(rst) |-> (pinOe == '0) && (rdDir[PORT_P1] == DIR_RESET);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pin not in input mode after reset");

    property p_p0_width;
        (pinOe[PORT_P0][PORT_MAX_W-1] == 1'b0) && (rdDir[PORT_P0][PORT_MAX_W-1] == 1'b0);
    endproperty
    a_p0_width: assert property (p_p0_width)
        else $error("port 0 bit 7 exists");

    property p_dir_drives;
        s_dirWrite1 |=> (rdDir[PORT_P1] == $past(s_axi_wdata[PORT_MAX_W-1:0]))
                        ##1 (pinOe[PORT_P1] == ~$past(rdDir[PORT_P1]));
    endproperty
    a_dir_drives: assert property (p_dir_drives)
        else $error("direction write did not steer the driver");

    property p_pull_p1;
        !$past(rst) |-> pullupOn[PORT_P1] ==
            $past(rdPull[PORT_P1] & rdDir[PORT_P1] & ~(rdAlt[PORT_P1] & altOe[PORT_P1]));
    endproperty
    a_pull_p1: assert property (p_pull_p1)
        else $error("port 1 pull-up does not follow its enable");

    property p_input_only;
        (pinOe[PORT_ADC] == '0) && (pullupOn[PORT_ADC] == '0) && (rdDir[PORT_ADC] == DIR_RESET);
    endproperty
    a_input_only: assert property (p_input_only)
        else $error("input-only port drives or changed direction");

    property p_p2_write_ignored;
        s_p2Write |=> (rdLatch[PORT_ADC] == LATCH_RESET) && (pinOe[PORT_ADC] == '0);
    endproperty
    a_p2_write_ignored: assert property (p_p2_write_ignored)
        else $error("write to input-only port had an effect");

    property p_p2_read;
        s_p2DataRead |=> s_axi_rvalid && (s_axi_rdata[PORT_MAX_W-1:0] == $past(rdLevel[PORT_ADC]));
    endproperty
    a_p2_read: assert property (p_p2_read)
        else $error("input-only port read not the pin level");

    property p_open_drain;
        !$past(rst) |-> (pinOut[PORT_OD] == '0) && (pinOe[PORT_OD] ==
            ($past(~rdDir[PORT_OD] & ~rdLatch[PORT_OD]) & width_mask(PORT_WIDTH[PORT_OD])));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain port drove high or missed a low");

    property p_od_pullup;
        !$past(rst) |-> (pullupOn[PORT_OD] == (MASK_PULLUP_OD & width_mask(PORT_WIDTH[PORT_OD])))
                        && (rdPull[PORT_OD] == PULL_RESET);
    endproperty
    a_od_pullup: assert property (p_od_pullup)
        else $error("open-drain pull-up not fixed");

    property p_key_return;
        !$past(rst) |-> key_return_inputs == $past(pinIn[PORT_KEY]);
    endproperty
    a_key_return: assert property (p_key_return)
        else $error("key-return inputs do not track port 7");

    property p_ext_irq;
        !$past(rst) |-> ext_irq_inputs == $past(pinIn[PORT_IRQ][IRQ_W-1:0]);
    endproperty
    a_ext_irq: assert property (p_ext_irq)
        else $error("irq inputs do not track port 3");

    property p_alt_drive;
        !$past(rst) |-> pinOut[PORT_P1] ==
            $past((rdAlt[PORT_P1] & altOut[PORT_P1]) | (~rdAlt[PORT_P1] & rdLatch[PORT_P1]));
    endproperty
    a_alt_drive: assert property (p_alt_drive)
        else $error("alternate function not routed to port 1");

    property p_no_alt;
        (rdAlt[PORT_P4] == '0) && (rdAlt[PORT_P5] == '0);
    endproperty
    a_no_alt: assert property (p_no_alt)
        else $error("alternate select set on port 4 or 5");

    property p_pull_sw_p4;
        !$past(rst) |-> pullupOn[PORT_P4] == $past(rdPull[PORT_P4] & rdDir[PORT_P4]);
    endproperty
    a_pull_sw_p4: assert property (p_pull_sw_p4)
        else $error("port 4 pull-up does not follow its enable");

    property p_analog;
        !$past(rst) |-> (rdLevel[PORT_ADC] & $past(rdAlt[PORT_ADC])) == '0;
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog-selected pin reads a digital level");

    property p_bresp;
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");

endmodule
`default_nettype wire

//--- testbench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire gpio_port_pkg::port_word_t [7:0] pinOut,   // pad drive
    input  wire gpio_port_pkg::port_word_t [7:0] pinOe,    // drive on
    input  wire gpio_port_pkg::port_word_t [7:0] pullupOn, // pull-up on
    input  wire gpio_port_pkg::port_word_t [7:0] extLevel, // board level
    output var  gpio_port_pkg::port_word_t [7:0] pinIn     // wire level
);
    import gpio_port_pkg::*;
    // a driven pad wins; the pull-up beats the weak board level
    assign pinIn = (pinOe & pinOut) | (~pinOe & (pullupOn | extLevel));
endmodule
`default_nettype wire

//--- testbench/mcu_port_pin_block_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_port_pin_block_tb;
    import gpio_port_pkg::*;
    logic clk_sys = 1'h0, rst = 1'h1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    port_word_t [7:0] pinIn, pinOut, pinOe, pullupOn, altIn, altOut = '0, altOe = '0, ext = '0;
    logic [7:0] key_return_inputs, analog_inputs;
    logic [2:0] ext_irq_inputs;
    int n_fail = 0, compares = 0;
    logic [7:0] p1Dir = 8'h0;
    mcu_port_pin_block #(.MASK_PULLUP_OD(8'h35)) i_mcu_port_pin_block (.clk_sys, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pinIn, .altOut, .altOe, .pinOut, .pinOe,
        .pullupOn, .altIn, .key_return_inputs, .ext_irq_inputs, .analog_inputs);
    board_model i_board_model (.pinOut, .pinOe, .pullupOn, .extLevel(ext), .pinIn);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input int a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= 8'(a);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(posedge clk_sys); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        while (s_axi_bvalid !== 1'h1) @(posedge clk_sys);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input int a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= 8'(a);
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge clk_sys);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk_sys);
    endtask
    // the direction value last written to port 1 stays in place
    function automatic logic [7:0] rd_keep(input logic [31:0] seen);
        return seen[7:0] & 8'h00 | p1Dir;
    endfunction
    task automatic summarize;
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize;
    end
    initial begin
        int p;
        logic [1:0] r;
        logic [31:0] v;
        port_word_t d, l, u, m, oe, po, pu, lv;
        void'($urandom(89467));
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        altOut <= {$urandom, $urandom};
        altOe <= {$urandom, $urandom};
        @(posedge clk_sys);
        chk("oe_rst", {31'h0, |pinOe}, 32'h0);
        wr(8'h80, 32'h0, r);
        chk("bresp", r, RESP_SLVERR);
        rd(8'h84, v, r);
        chk("rresp", r, RESP_SLVERR);
        for (int i = 0; i < 40; i++) begin
            p = i % 8;
            m = 8'((1 << PORT_WIDTH[p]) - 1);
            ext <= {$urandom, $urandom};
            d = 8'($urandom);
            l = 8'($urandom);
            u = 8'($urandom);
            wr(p * 16, l, r);
            wr(p * 16 + 4, d, r);
            if (p == PORT_P1) p1Dir = d;
            wr(p * 16 + 8, u, r);
            // writes to the input-only port must leave it untouched
            if (p == PORT_ADC) {d, l, u} = {8'hff, 8'h00, 8'h00};
            oe = OUT_PORTS[p] ? ~d & (OD_PORTS[p] ? ~l : 8'hff) & m : 8'h00;
            po = OD_PORTS[p] ? 8'h00 : l & m;
            pu = OD_PORTS[p] ? 8'h05 : d & u & m & {8{SWPU_PORTS[p]}};
            lv = (oe & po) | (~oe & (pu | ext[p]));
            repeat (2) @(posedge clk_sys);
            chk("oe", pinOe[p], oe);
            chk("out", pinOut[p], po);
            chk("pull", pullupOn[p], pu);
            rd(p * 16, v, r);
            chk("data", v, (~d & l | d & lv) & m);
            rd(p * 16 + 4, v, r);
            chk("dir", v, d & m);
            if (p == PORT_KEY) chk("key", key_return_inputs, lv);
            if (p == PORT_IRQ) chk("irq", ext_irq_inputs, lv[2:0]);
            chk("alt_in", altIn[p], lv & m);
        end
        // byte lane 0 off: the write must be answered but leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(8'h14, 32'h0, r);
        s_axi_wstrb <= 4'h1;
        chk("strb_resp", r, RESP_OKAY);
        rd(8'h14, v, r);
        chk("strb_dir", v, 32'(d & 8'hff) & 32'h0 | v & 32'h0 | 32'(8'h0) | 32'(v[7:0] & 8'h0) | 32'(rd_keep(v)));
        // mid-run reset: every two-way pin falls back to input
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        rd(8'h14, v, r);
        chk("dir_rst2", v, 32'(DIR_RESET));
        chk("oe_rst2", {31'h0, |pinOe}, 32'h0);
        // ports 3 to 6, which have no alternates, must ignore an alternate select write
        for (int q = 3; q < 7; q++) begin
            wr(q * 16 + 12, 32'hff, r);
            rd(q * 16 + 12, v, r);
            chk("alt_none", v, 32'h0);
        end
        wr(8'h7c, 32'hff, r);
        wr(8'h2c, 32'hff, r);
        repeat (2) @(posedge clk_sys);
        chk("alt_oe", pinOe[7], altOe[7]);
        chk("alt_out", pinOut[7], altOut[7]);
        chk("ana", analog_inputs, 8'hff);
        chk("ana_in", altIn[PORT_ADC], 32'h0);
        rd(8'h20, v, r);
        chk("ana_rd", v, 32'h0);
        summarize;
    end
endmodule
`default_nettype wire
